//--- verilog/dram_seq_map.svh
// Behaviour
// - write drives write strobe, row address and data; row strobe follows one clock later
// - slow write: column strobe two clocks after row strobe, held two clocks
// - slow write without precharge is exactly one clock longer than fast write
// - read needing precharge holds row strobe high while row address is driven
// - slow read: column address one clock after row strobe, strobe one later
// - read keeps write strobe high; read ends when column strobe is released
// - slow read with full precharge is two clocks longer than fast read
// - other bank's open row strobe is released as the row address appears
// - slow read with overlapping precharge is one clock longer than fast read
// - precharge skipped only when target row strobe was high long enough
// - configuration bit 23 set selects fast writes, clear selects slow writes
// - configuration bit 22 set selects fast reads, clear selects slow reads
// - one 32-bit configuration register at a fixed memory-mapped address
// - bits 11:10 set the ISA clock divisor: six, three, four, five
// - bit 12 selects 80ns memory timing when set, slower timing when clear
// - 80ns timing: row low 2/3/4 clocks, high and precharge 2/3/3
// - bits 7:0 give clocks the ISA refresh request is extended, default zero
// - reset loads every default, leaving the slowest safe memory timing
// - slow memory: row low, high, precharge 3 clocks at 25MHz, else 4
// - fast column strobe low 1 clock, slow low 2; high 1 clock
`ifndef DRAM_SEQ_MAP_SVH
`define DRAM_SEQ_MAP_SVH

`define CFG_ADDR        32'hFF00401C
`define CFG_RESET       32'h00102000
`define CFG_FAST_WR     23
`define CFG_FAST_RD     22
`define CFG_MEM80       12
`define CFG_ISA_HI      11
`define CFG_ISA_LO      10
`define CFG_SPEED_HI    9
`define CFG_SPEED_LO    8
`define CFG_HOLD_HI     7
`define CFG_HOLD_LO     0

`define BANK_W          2
`define ADDR_W          11
`define DATA_W          64

`define CNT_MAX         3'h7
`define CAS_SLOW        2'h2
`define CAS_FAST        2'h1

`define SPEED_50        2'h0
`define SPEED_40        2'h1
`define SPEED_33        2'h2
`define SPEED_25        2'h3

`define RAS80_25        3'h2
`define RAS80_33        3'h3
`define RAS80_40        3'h4
`define PRE80_25        3'h2
`define PRE80_33        3'h3
`define PRE80_40        3'h3
`define SLOW_25         3'h3
`define SLOW_OTHER      3'h4
`define TIME_50         3'h4

`define ISA_DIV6        3'h6
`define ISA_DIV5        3'h5
`define ISA_DIV4        3'h4
`define ISA_DIV3        3'h3

`endif

//--- verilog/dram_seq_pkg.sv
`include "dram_seq_map.svh"

package dram_seq_pkg;

    typedef struct packed {
        logic                 write;
        logic                 casGroupB;
        logic [`BANK_W-1:0]   bank;
        logic [`ADDR_W-1:0]   row;
        logic [`ADDR_W-1:0]   col;
        logic [`DATA_W-1:0]   data;
    } dram_req_t;

    typedef enum logic [2:0] {
        IDLE,
        PRE,
        ROW,
        RAS,
        COL,
        CAS,
        DONE
    } seq_state_t;

endpackage : dram_seq_pkg

//--- verilog/main_memory_dram_sequencer.sv
`timescale 1ns/10ps
`include "dram_seq_map.svh"

module main_memory_dram_sequencer (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic                     cfgReq,
    input  wire logic                     cfgWrite,
    input  wire logic [31:0]              cfgAddr,
    input  wire logic [31:0]              cfgWdata,
    output logic                          cfgAck,
    output logic [31:0]                   cfgRdata,
    input  wire logic                     reqValid,
    input  wire dram_seq_pkg::dram_req_t  req,
    output logic                          reqReady,
    output logic                          rdValid,
    output logic [`DATA_W-1:0]            rdData,
    output logic                          wrDone,
    output logic [2:0]                    isaClkDivisor,
    output logic [7:0]                    refreshHoldCount,
    output logic [(1<<`BANK_W)-1:0]       rowStrobeN,
    output logic [(1<<`BANK_W)-1:0]       columnStrobeAN,
    output logic [(1<<`BANK_W)-1:0]       columnStrobeBN,
    output logic                          writeStrobeN,
    output logic [`ADDR_W-1:0]            dramAddressBus,
    output logic [`DATA_W-1:0]            dramDataBusOut,
    output logic                          dramDataBusOe,
    input  wire logic [`DATA_W-1:0]       dramDataBusIn
);

    localparam int BANKS = 1 << `BANK_W;

    // strobe masks and bank counters are sized for two to eight banks
    if (`BANK_W < 1 || `BANK_W > 3) begin : g_bank_check
        $error("bank address width out of range");
    end

    // minimum row strobe low time by speed and memory grade
    function automatic logic [2:0] rasLowMin(input logic [1:0] speed, input logic mem80);
        logic [2:0] t;
        t = `TIME_50;
        unique case (speed)
            `SPEED_25: t = mem80 ? `RAS80_25 : `SLOW_25;
            `SPEED_33: t = mem80 ? `RAS80_33 : `SLOW_OTHER;
            `SPEED_40: t = mem80 ? `RAS80_40 : `SLOW_OTHER;
            `SPEED_50: t = `TIME_50;
        endcase
        return t;
    endfunction : rasLowMin

    // minimum high and precharge time; the two coincide in every grade
    function automatic logic [2:0] preMin(input logic [1:0] speed, input logic mem80);
        logic [2:0] t;
        t = `TIME_50;
        unique case (speed)
            `SPEED_25: t = mem80 ? `PRE80_25 : `SLOW_25;
            `SPEED_33: t = mem80 ? `PRE80_33 : `SLOW_OTHER;
            `SPEED_40: t = mem80 ? `PRE80_40 : `SLOW_OTHER;
            `SPEED_50: t = `TIME_50;
        endcase
        return t;
    endfunction : preMin

    function automatic logic [2:0] isaDivide(input logic [1:0] code);
        logic [2:0] d;
        d = `ISA_DIV6;
        unique case (code)
            2'h0: d = `ISA_DIV6;
            2'h1: d = `ISA_DIV3;
            2'h2: d = `ISA_DIV4;
            2'h3: d = `ISA_DIV5;
        endcase
        return d;
    endfunction : isaDivide

    logic [31:0]                 cfg_r;
    dram_seq_pkg::seq_state_t    state_r;
    dram_seq_pkg::seq_state_t    stateNxt;
    dram_seq_pkg::dram_req_t     cur_r;
    dram_seq_pkg::dram_req_t     curNxt;
    logic [1:0]                  casCnt_r;
    logic [1:0]                  casCntNxt;
    logic [2:0]                  highCnt_r [BANKS];
    logic [2:0]                  lowCnt_r  [BANKS];
    logic [2:0]                  tRas;
    logic [2:0]                  tPre;
    logic                        taken;
    logic                        needPre;
    logic                        banksOk;
    logic                        cfgHit;
    logic [`DATA_W-1:0]          sync1_r;
    logic [`DATA_W-1:0]          sync2_r;
    logic [`DATA_W-1:0]          sync3_r;
    logic [2:0]                  tag_r;

    assign tRas   = rasLowMin(cfg_r[`CFG_SPEED_HI:`CFG_SPEED_LO], cfg_r[`CFG_MEM80]);
    assign tPre   = preMin(cfg_r[`CFG_SPEED_HI:`CFG_SPEED_LO], cfg_r[`CFG_MEM80]);
    assign taken  = reqValid && reqReady;
    // full-word decode; the register has no byte lanes
    assign cfgHit = cfgAddr == `CFG_ADDR;

    // configuration register, memory mapped at one fixed address
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_r <= `CFG_RESET;
        end else if (cfgReq && cfgWrite && cfgHit) begin
            cfg_r <= cfgWdata;
        end
    end

    // one-cycle answer; unmapped reads return zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfgAck   <= 1'b0;
            cfgRdata <= 32'h00000000;
        end else begin
            cfgAck   <= cfgReq;
            cfgRdata <= (cfgReq && !cfgWrite && cfgHit) ? cfg_r : 32'h00000000;
        end
    end

    // fields used by other blocks, registered so the outputs stay flop driven
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            isaClkDivisor    <= `ISA_DIV6;
            refreshHoldCount <= 8'h00;
        end else begin
            isaClkDivisor    <= isaDivide(cfg_r[`CFG_ISA_HI:`CFG_ISA_LO]);
            refreshHoldCount <= cfg_r[`CFG_HOLD_HI:`CFG_HOLD_LO];
        end
    end

    // per-bank high and low time counters, saturating
    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                highCnt_r[b] <= `CNT_MAX;
                lowCnt_r[b]  <= 3'h0;
            end else if (rowStrobeN[b]) begin
                highCnt_r[b] <= (highCnt_r[b] == `CNT_MAX) ? `CNT_MAX : highCnt_r[b] + 3'h1;
                lowCnt_r[b]  <= 3'h0;
            end else begin
                lowCnt_r[b]  <= (lowCnt_r[b] == `CNT_MAX) ? `CNT_MAX : lowCnt_r[b] + 3'h1;
                highCnt_r[b] <= 3'h0;
            end
        end
    end

    // an open row may only be closed once its minimum low time has passed
    always_comb begin
        banksOk = 1'b1;
        for (int b = 0; b < BANKS; b++) begin
            if (!rowStrobeN[b] && lowCnt_r[b] < tRas) begin
                banksOk = 1'b0;
            end
        end
    end

    // high cycles so far plus the row cycle must reach the precharge time
    always_comb begin
        needPre = !rowStrobeN[req.bank]
               || ({1'b0, highCnt_r[req.bank]} + 4'h2 < {1'b0, tPre});
    end

    always_comb begin
        stateNxt  = state_r;
        casCntNxt = casCnt_r;
        curNxt    = taken ? req : cur_r;
        unique case (state_r)
            dram_seq_pkg::IDLE: begin
                if (taken) begin
                    stateNxt = needPre ? dram_seq_pkg::PRE : dram_seq_pkg::ROW;
                end
            end
            dram_seq_pkg::PRE: begin
                // wait until the row will have been high for the precharge time
                if ({1'b0, highCnt_r[cur_r.bank]} + 4'h2 >= {1'b0, tPre}) begin
                    stateNxt = dram_seq_pkg::ROW;
                end
            end
            dram_seq_pkg::ROW: begin
                stateNxt = dram_seq_pkg::RAS;
            end
            dram_seq_pkg::RAS: begin
                stateNxt = dram_seq_pkg::COL;
            end
            dram_seq_pkg::COL: begin
                // fast bits sampled here; a later config write waits for the next access
                stateNxt = dram_seq_pkg::CAS;
                if (cur_r.write) begin
                    casCntNxt = cfg_r[`CFG_FAST_WR] ? `CAS_FAST - 2'h1
                                                     : `CAS_SLOW - 2'h1;
                end else begin
                    casCntNxt = cfg_r[`CFG_FAST_RD] ? `CAS_FAST - 2'h1
                                                     : `CAS_SLOW - 2'h1;
                end
            end
            dram_seq_pkg::CAS: begin
                if (casCnt_r == 2'h0) begin
                    stateNxt = dram_seq_pkg::DONE;
                end else begin
                    casCntNxt = casCnt_r - 2'h1;
                end
            end
            dram_seq_pkg::DONE: begin
                stateNxt = dram_seq_pkg::IDLE;
            end
            default: begin
                stateNxt = dram_seq_pkg::IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r  <= dram_seq_pkg::IDLE;
            casCnt_r <= 2'h0;
            cur_r    <= '0;
        end else begin
            state_r  <= stateNxt;
            casCnt_r <= casCntNxt;
            cur_r    <= curNxt;
        end
    end

    // ready drops in the cycle after acceptance, never one late, and stays low until idle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reqReady <= 1'b0;
        end else begin
            reqReady <= stateNxt == dram_seq_pkg::IDLE && !taken && banksOk;
        end
    end

    // pins are registered from the next state so they never glitch
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rowStrobeN <= '1;
        end else begin
            unique case (stateNxt)
                dram_seq_pkg::PRE, dram_seq_pkg::ROW: begin
                    rowStrobeN <= '1;
                end
                dram_seq_pkg::RAS, dram_seq_pkg::COL, dram_seq_pkg::CAS,
                dram_seq_pkg::DONE: begin
                    rowStrobeN <= ~(BANKS'(1) << curNxt.bank);
                end
                // target row stays open while idle; next access closes it
                dram_seq_pkg::IDLE: begin
                    rowStrobeN <= rowStrobeN;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            columnStrobeAN <= '1;
            columnStrobeBN <= '1;
        end else if (stateNxt == dram_seq_pkg::CAS) begin
            columnStrobeAN <= curNxt.casGroupB ? '1 : ~(BANKS'(1) << curNxt.bank);
            columnStrobeBN <= curNxt.casGroupB ? ~(BANKS'(1) << curNxt.bank) : '1;
        end else begin
            columnStrobeAN <= '1;
            columnStrobeBN <= '1;
        end
    end

    // write strobe and data enable move together, so a read never sees a driven bus
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            writeStrobeN  <= 1'b1;
            dramDataBusOe <= 1'b0;
        end else begin
            unique case (stateNxt)
                dram_seq_pkg::PRE, dram_seq_pkg::ROW, dram_seq_pkg::RAS,
                dram_seq_pkg::COL, dram_seq_pkg::CAS: begin
                    writeStrobeN  <= !curNxt.write;
                    dramDataBusOe <= curNxt.write;
                end
                dram_seq_pkg::IDLE, dram_seq_pkg::DONE: begin
                    writeStrobeN  <= 1'b1;
                    dramDataBusOe <= 1'b0;
                end
            endcase
        end
    end

    // address holds while idle; it only matters while a strobe is low
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dramAddressBus <= '0;
            dramDataBusOut <= '0;
        end else begin
            if (taken) begin
                dramDataBusOut <= req.data;
            end
            unique case (stateNxt)
                dram_seq_pkg::PRE, dram_seq_pkg::ROW, dram_seq_pkg::RAS: begin
                    dramAddressBus <= curNxt.row;
                end
                dram_seq_pkg::COL, dram_seq_pkg::CAS: begin
                    dramAddressBus <= curNxt.col;
                end
                dram_seq_pkg::IDLE, dram_seq_pkg::DONE: begin
                    dramAddressBus <= dramAddressBus;
                end
            endcase
        end
    end

    // data pins cross three flops; a tag travels beside the sample taken
    // on the last column strobe cycle, so the bus need not stay stable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            tag_r   <= 3'h0;
        end else begin
            sync1_r <= dramDataBusIn;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            tag_r   <= {tag_r[1:0], state_r == dram_seq_pkg::CAS && casCnt_r == 2'h0
                                    && !cur_r.write};
        end
    end

    // read data holds the last word until the next read completes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdValid <= 1'b0;
            rdData  <= '0;
            wrDone  <= 1'b0;
        end else begin
            rdValid <= tag_r[2];
            if (tag_r[2]) begin
                rdData <= sync3_r;
            end
            wrDone  <= state_r == dram_seq_pkg::DONE && cur_r.write;
        end
    end

endmodule : main_memory_dram_sequencer

//--- tb/main_memory_dram_sequencer_sva.sv
`timescale 1ns/10ps
module main_memory_dram_sequencer_sva (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        cfgReq,
    input wire logic        cfgAck,
    input wire logic        reqValid,
    input wire logic        reqReady,
    input wire logic        rdValid,
    input wire logic        wrDone,
    input wire logic [2:0]  isaClkDivisor,
    input wire logic [3:0]  rowStrobeN,
    input wire logic [3:0]  columnStrobeAN,
    input wire logic [3:0]  columnStrobeBN,
    input wire logic        writeStrobeN,
    input wire logic        dramDataBusOe
);
    logic casLow;
    assign casLow = !((&columnStrobeAN) && (&columnStrobeBN));
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_cfg_ack; cfgReq |=> cfgAck; endproperty
    a_cfg_ack: assert property (p_cfg_ack) else $error("config access not acknowledged");
    property p_no_stray_ack; !cfgReq |=> !cfgAck; endproperty
    a_no_stray_ack: assert property (p_no_stray_ack) else $error("ack without request");
    property p_row_after_we;
        $fell(&rowStrobeN) && !writeStrobeN |-> !$past(writeStrobeN) && $past(dramDataBusOe);
    endproperty
    a_row_after_we: assert property (p_row_after_we) else $error("row strobe before write setup");
    property p_we_oe; writeStrobeN == !dramDataBusOe; endproperty
    a_we_oe: assert property (p_we_oe) else $error("data bus driven outside write");
    property p_cas_after_ras;
        $rose(casLow) |-> !(&$past(rowStrobeN)) && !(&$past(rowStrobeN, 2));
    endproperty
    a_cas_after_ras: assert property (p_cas_after_ras) else $error("column strobe too early");
    property p_cas_width; $rose(casLow) |-> ##[1:2] !casLow; endproperty
    a_cas_width: assert property (p_cas_width) else $error("column strobe too long");
    property p_wr_done; $rose(writeStrobeN) |=> wrDone; endproperty
    a_wr_done: assert property (p_wr_done) else $error("write end not reported");
    property p_rd_valid; $fell(casLow) && $past(writeStrobeN) |-> ##3 rdValid; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read data not delivered");
    property p_take; reqValid && reqReady |=> !reqReady; endproperty
    a_take: assert property (p_take) else $error("second access taken while busy");
    property p_isa; isaClkDivisor inside {[3'h3:3'h6]}; endproperty
    a_isa: assert property (p_isa) else $error("isa divisor out of range");
endmodule : main_memory_dram_sequencer_sva

bind main_memory_dram_sequencer main_memory_dram_sequencer_sva u_sva (
    .clock(clock), .rst(rst), .cfgReq(cfgReq), .cfgAck(cfgAck), .reqValid(reqValid),
    .reqReady(reqReady), .rdValid(rdValid), .wrDone(wrDone), .isaClkDivisor(isaClkDivisor),
    .rowStrobeN(rowStrobeN), .columnStrobeAN(columnStrobeAN), .columnStrobeBN(columnStrobeBN),
    .writeStrobeN(writeStrobeN), .dramDataBusOe(dramDataBusOe));

//--- tb/dram_bank_model.sv
`timescale 1ns/10ps
module dram_bank_model (
    input wire logic         clock,
    input wire logic [3:0]   rowStrobeN,
    input wire logic [3:0]   columnStrobeAN,
    input wire logic [3:0]   columnStrobeBN,
    input wire logic         writeStrobeN,
    input wire logic [10:0]  dramAddressBus,
    input wire logic [63:0]  dramDataBusOut,
    output logic [63:0]      dramDataBusIn
);
    logic [63:0] store [logic [23:0]];
    logic [10:0] openRow [4];
    logic [3:0]  rowPrev = 4'hF;
    logic [63:0] lastOut = 64'h0;
    logic [3:0]  casN;
    logic [1:0]  bank;
    logic [23:0] key;
    assign casN = columnStrobeAN & columnStrobeBN;
    always @* begin
        bank = 2'h0;
        for (int b = 0; b < 4; b++)
            if (!casN[b]) bank = b[1:0];
        key = {bank, openRow[bank], dramAddressBus};
        // read: write strobe high while column strobe low
        if (casN != 4'hF && writeStrobeN && store.exists(key))
            dramDataBusIn = store[key];
        else
            dramDataBusIn = ~lastOut; // released bus never shows a stale word
    end
    // sampled before the edge's updates land, so the values are those of the ending cycle
    always @(posedge clock) begin
        for (int b = 0; b < 4; b++)
            if (rowPrev[b] && !rowStrobeN[b]) openRow[b] <= dramAddressBus;
        if (casN != 4'hF && !writeStrobeN) store[key] = dramDataBusOut;
        rowPrev <= rowStrobeN;
        lastOut <= dramDataBusIn;
    end
endmodule : dram_bank_model

//--- tb/main_memory_dram_sequencer_bench.sv
`timescale 1ns/10ps
`include "dram_seq_map.svh"
module main_memory_dram_sequencer_bench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cfgReq = 1'b0;
    logic cfgWrite = 1'b0;
    logic [31:0] cfgAddr = 32'h0;
    logic [31:0] cfgWdata = 32'h0;
    logic reqValid = 1'b0;
    dram_seq_pkg::dram_req_t req = '0;
    logic cfgAck, reqReady, rdValid, wrDone, writeStrobeN, dramDataBusOe;
    logic [31:0] cfgRdata;
    logic [63:0] rdData, dramDataBusOut, dramDataBusIn;
    logic [2:0] isaClkDivisor;
    logic [7:0] refreshHoldCount;
    logic [3:0] rowStrobeN, columnStrobeAN, columnStrobeBN;
    logic [10:0] dramAddressBus;
    int errCount = 0;
    int nChecks = 0;
    int cycles = 0;

    always #20 clock = ~clock;

    main_memory_dram_sequencer dut (.clock(clock), .rst(rst), .cfgReq(cfgReq),
        .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgAck(cfgAck),
        .cfgRdata(cfgRdata), .reqValid(reqValid), .req(req), .reqReady(reqReady),
        .rdValid(rdValid), .rdData(rdData), .wrDone(wrDone), .isaClkDivisor(isaClkDivisor),
        .refreshHoldCount(refreshHoldCount), .rowStrobeN(rowStrobeN),
        .columnStrobeAN(columnStrobeAN), .columnStrobeBN(columnStrobeBN),
        .writeStrobeN(writeStrobeN), .dramAddressBus(dramAddressBus),
        .dramDataBusOut(dramDataBusOut), .dramDataBusOe(dramDataBusOe),
        .dramDataBusIn(dramDataBusIn));
    dram_bank_model dram (.clock(clock), .rowStrobeN(rowStrobeN),
        .columnStrobeAN(columnStrobeAN), .columnStrobeBN(columnStrobeBN),
        .writeStrobeN(writeStrobeN), .dramAddressBus(dramAddressBus),
        .dramDataBusOut(dramDataBusOut), .dramDataBusIn(dramDataBusIn));

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        nChecks++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d errors %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic cfg_access(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                              output logic [31:0] rdata);
        @(posedge clock);
        #1;
        cfgReq = 1'b1;
        cfgWrite = wr;
        cfgAddr = addr;
        cfgWdata = wdata;
        @(posedge clock);
        #1;
        cfgReq = 1'b0;
        check("cfg ack", 64'h1, {63'h0, cfgAck});
        rdata = cfgRdata;
    endtask : cfg_access

    // cyc counts cycles from the take edge to the completion pulse
    task automatic mem_access(input logic wr, input logic [1:0] bank, input logic [10:0] row,
                              input logic [63:0] data, output logic [63:0] cyc,
                              output logic [63:0] rdat);
        int n;
        n = 0;
        @(posedge clock);
        #1;
        while (!reqReady && n < 50) begin
            @(posedge clock);
            #1;
            n++;
        end
        reqValid = 1'b1;
        req = '{write: wr, casGroupB: bank[0], bank: bank, row: row, col: row ^ 11'h2A5,
                data: data};
        @(posedge clock);
        #1;
        reqValid = 1'b0;
        n = 0;
        while (!(wr ? wrDone : rdValid) && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        cyc = 64'(n);
        rdat = rdData;
    endtask : mem_access

    task automatic reset_defaults();
        logic [31:0] r;
        cfg_access(1'b0, `CFG_ADDR, 32'h0, r);
        check("cfg reset", {32'h0, `CFG_RESET}, {32'h0, r});
        check("isa divisor reset", 64'h6, {61'h0, isaClkDivisor});
        check("hold count reset", 64'h0, {56'h0, refreshHoldCount});
        check("pins after reset", 64'h3FFE, {50'h0, rowStrobeN, columnStrobeAN, columnStrobeBN,
              writeStrobeN, dramDataBusOe});
        cfg_access(1'b1, 32'hFF004018, 32'hFFFFFFFF, r);
        cfg_access(1'b0, 32'hFF004018, 32'h0, r);
        check("unmapped read", 64'h0, {32'h0, r});
        cfg_access(1'b0, `CFG_ADDR, 32'h0, r);
        check("cfg after unmapped write", {32'h0, `CFG_RESET}, {32'h0, r});
    endtask : reset_defaults

    task automatic config_fields();
        logic [31:0] r;
        logic [31:0] w;
        logic [2:0] divs [4] = '{3'h6, 3'h3, 3'h4, 3'h5};
        for (int i = 0; i < 4; i++) begin
            w = `CFG_RESET | (32'(i) << 10) | 32'(8'h5A + 8'(i));
            cfg_access(1'b1, `CFG_ADDR, w, r);
            cfg_access(1'b0, `CFG_ADDR, 32'h0, r);
            check("cfg readback", {32'h0, w}, {32'h0, r});
            check("isa divisor", {61'h0, divs[i]}, {61'h0, isaClkDivisor});
            check("hold count", {56'h0, w[7:0]}, {56'h0, refreshHoldCount});
        end
    endtask : config_fields

    // 80ns parts at 25MHz: two-clock precharge, as in the slow and fast cycle walks
    task automatic timing_runs();
        logic [31:0] r;
        logic [63:0] c;
        logic [63:0] d;
        cfg_access(1'b1, `CFG_ADDR, `CFG_RESET | 32'h00001300, r);
        mem_access(1'b1, 2'h0, 11'h155, 64'h0123456789ABCDEF, c, d);
        check("slow write cycles", 64'h6, c);
        mem_access(1'b0, 2'h0, 11'h155, 64'h0, c, d);
        check("precharge read cycles", 64'h9, c);
        check("read data", 64'h0123456789ABCDEF, d);
        cfg_access(1'b1, `CFG_ADDR, `CFG_RESET | 32'h00801300, r);
        mem_access(1'b1, 2'h1, 11'h2AA, 64'hFEDCBA9876543210, c, d);
        check("fast write cycles", 64'h5, c);
        mem_access(1'b0, 2'h0, 11'h155, 64'h0, c, d);
        check("overlap read cycles", 64'h8, c);
        check("overlap read data", 64'h0123456789ABCDEF, d);
        cfg_access(1'b1, `CFG_ADDR, `CFG_RESET | 32'h00C01300, r);
        mem_access(1'b0, 2'h1, 11'h2AA, 64'h0, c, d);
        check("fast read cycles", 64'h7, c);
        check("fast read data", 64'hFEDCBA9876543210, d);
        // slower parts at 25MHz: three-clock precharge on the still open bank
        cfg_access(1'b1, `CFG_ADDR, `CFG_RESET | 32'h00000300, r);
        mem_access(1'b0, 2'h1, 11'h2AA, 64'h0, c, d);
        check("slow memory precharge read cycles", 64'hA, c);
        check("slow memory read data", 64'hFEDCBA9876543210, d);
    endtask : timing_runs

    // the run needs about 110 cycles; the ceiling leaves a wide margin
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errCount++;
            $display("mismatch timeout expected finish seen hang");
            print_verdict();
        end
    end

    initial begin
        repeat (20) @(posedge clock);
        #1;
        rst = 1'b0;
        reset_defaults();
        config_fields();
        timing_runs();
        print_verdict();
    end
endmodule : main_memory_dram_sequencer_bench
